// >>> pcu_pin_model.sv
// board pins: pull-ups on all port lines
// assumes ext_* is the keypad side, 1 = released
`timescale 1ns/1ps
module pcu_pin_model (
    input wire logic [7:0] io_a_oe, // pulls low
    input wire logic [1:0] mixed_oe, // pulls low
    input wire logic [7:0] ext_a, // keypad
    input wire logic [7:0] ext_b, // keypad
    output logic [7:0] io_a_in, // line level
    output logic [7:0] mixed_in // line level
);
    assign io_a_in = ext_a & ~io_a_oe;
    assign mixed_in = {ext_b[7:2], ext_b[1:0] & ~mixed_oe};
endmodule : pcu_pin_model

// >>> pcu_pkg.sv
// package for the port and carrier unit: data-memory addresses, reset values, instruction-clock divider count
// assumes a core that reaches the ports through a byte-wide data-memory access port
package pcu_pkg;
    localparam logic [7:0] ADDR_EIGHT_BIT_IO = 8'h12;
    localparam logic [7:0] ADDR_MIXED_INPUT = 8'h14;
    localparam logic [7:0] ADDR_ONE_BIT_OUT = 8'h16;
    localparam logic [7:0] RST_EIGHT_BIT_IO = 8'hff;
    localparam logic [7:0] RST_MIXED_LATCH = 8'hff;
    localparam logic RST_ONE_BIT = 1'b1;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    localparam int MIXED_BIDIR_BITS = 2;
endpackage : pcu_pkg

// >>> pcu_port_unit.sv
// port and carrier unit: eight-bit io port, mixed input port, one-bit output / carrier pin
// assumes the core gives a one-cycle write strobe with address and data, and a read address;
// pins reach this block asynchronously and are synchronised here
`timescale 1ns/1ps
module pcu_port_unit #(
    parameter bit CARRIER_MODE = 1'b1,     // option: 1 carrier, 0 level
    parameter bit M_IS_THREE = 1'b0,       // option: m = 3 when set
    parameter logic [1:0] N_EXP = 2'd0,    // option: n in 0..3
    parameter bit THIRD_DUTY = 1'b0,       // option: 1/3 duty where m=3, n>0
    parameter logic [7:0] WAKE_EN = 8'h00  // option: per-line wake enable
) (
    input wire logic clk_sys,              // system clock 100 MHz
    input wire logic srst,                 // synchronous reset, high
    input wire logic [7:0] mem_addr,       // data-memory address
    input wire logic mem_wr,               // write strobe, one cycle
    input wire logic [7:0] mem_wdata,      // write data
    output logic [7:0] mem_rdata,          // read data, registered
    input wire logic halt_active,          // core is halted
    output logic wake_ff,                  // one-cycle wake pulse
    input wire logic [7:0] io_a_in,        // eight-bit port pin levels
    output logic [7:0] io_a_out,           // always low: open drain
    output logic [7:0] io_a_oe,            // high pulls pin low
    input wire logic [7:0] mixed_in,       // mixed port pin levels
    output logic [1:0] mixed_out,          // always low: open drain
    output logic [1:0] mixed_oe,           // high pulls pin low
    output logic shared_pin_out,           // shared level / carrier pin
    output logic shared_pin_oe             // always driven
);
    logic [7:0] a_latch_ff;
    logic [1:0] b_latch_ff;
    logic c_latch_ff;
    logic [7:0] a_s1_ff, a_s2_ff, b_s1_ff, b_s2_ff, b_prev_ff;
    logic [1:0] iclk_ff;
    logic [4:0] cdiv_ff;
    logic car_ff;
    logic [7:0] rdata_ff;
    logic [7:0] a_oe_ff;
    logic [1:0] b_oe_ff;
    logic pin_ff;
    logic wake_pulse_ff;
    logic en_d_ff;

    wire sel_a = (mem_addr == pcu_pkg::ADDR_EIGHT_BIT_IO);
    wire sel_b = (mem_addr == pcu_pkg::ADDR_MIXED_INPUT);
    wire sel_c = (mem_addr == pcu_pkg::ADDR_ONE_BIT_OUT);
    // reads show synchronised pins for the io and mixed ports, the latch for the one-bit port; an rmw by the core reads then writes back whole byte
    wire [7:0] rd_val = sel_a ? a_s2_ff :
                        sel_b ? b_s2_ff :
                        sel_c ? {7'h00, c_latch_ff} : 8'h00;
    // instruction clock tick: one in four system cycles
    wire iclk_tick = (iclk_ff == pcu_pkg::INSTR_DIV_LAST);
    wire [4:0] period = M_IS_THREE ? 5'(3 << N_EXP) : 5'(2 << N_EXP);
    wire [4:0] third = M_IS_THREE ? 5'(1 << N_EXP) : 5'd0;
    wire [4:0] half = 5'(period >> 1);
    // m=2 always half; m=3,n=0 always third; else option
    wire use_third = M_IS_THREE && (N_EXP == 2'd0 || THIRD_DUTY);
    wire [4:0] high_cnt = use_third ? third : half;
    wire car_en = ~c_latch_ff;
    wire car_start = car_en & ~en_d_ff;
    wire [4:0] nxt_cdiv = (car_start || cdiv_ff == period - 5'd1) ? 5'd0 : cdiv_ff + 5'd1;
    wire nxt_pin = CARRIER_MODE ? (car_en & car_ff) : c_latch_ff;
    wire [7:0] wake_edges = b_prev_ff & ~b_s2_ff & WAKE_EN;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            a_latch_ff <= pcu_pkg::RST_EIGHT_BIT_IO;
            b_latch_ff <= pcu_pkg::RST_MIXED_LATCH[1:0];
            c_latch_ff <= pcu_pkg::RST_ONE_BIT;
        end else if (mem_wr) begin
            if (sel_a) a_latch_ff <= mem_wdata;
            if (sel_b) b_latch_ff <= mem_wdata[1:0];
            if (sel_c) c_latch_ff <= mem_wdata[0];
        end
    end

    always_ff @(posedge clk_sys) begin
        a_s1_ff <= io_a_in;
        a_s2_ff <= a_s1_ff;
        b_s1_ff <= mixed_in;
        b_s2_ff <= b_s1_ff;
        b_prev_ff <= srst ? 8'hff : b_s2_ff;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            iclk_ff <= 2'd0;
            cdiv_ff <= 5'd0;
            car_ff <= 1'b0;
            en_d_ff <= 1'b0;
        end else begin
            en_d_ff <= car_en;
            // the tick phase restarts with the carrier, else the first high could be cut to one cycle
            if (car_start) begin
                iclk_ff <= 2'd0;
                cdiv_ff <= 5'd0;
                car_ff <= 1'b1;
            end else begin
                iclk_ff <= iclk_ff + 2'd1;
                if (iclk_tick) begin
                    cdiv_ff <= nxt_cdiv;
                    car_ff <= (nxt_cdiv < high_cnt);
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_ff <= 8'h00;
            a_oe_ff <= 8'h00;
            b_oe_ff <= 2'b00;
            pin_ff <= ~CARRIER_MODE;
            wake_pulse_ff <= 1'b0;
        end else begin
            rdata_ff <= rd_val;
            a_oe_ff <= ~a_latch_ff;
            b_oe_ff <= ~b_latch_ff;
            pin_ff <= nxt_pin;
            wake_pulse_ff <= halt_active & (|wake_edges);
        end
    end

    assign mem_rdata = rdata_ff;
    assign io_a_oe = a_oe_ff;
    assign io_a_out = 8'h00;
    assign mixed_oe = b_oe_ff;
    assign mixed_out = 2'b00;
    assign shared_pin_out = pin_ff;
    assign shared_pin_oe = 1'b1;
    assign wake_ff = wake_pulse_ff;
endmodule : pcu_port_unit

// >>> pcu_port_unit_checker.sv
// assertions on the unit's ports, default build: carrier, divide by 2
// assumes bind onto pcu_port_unit
`timescale 1ns/1ps
module pcu_port_unit_checker (
    input wire logic clk_sys, srst, mem_wr, halt_active, wake_ff, shared_pin_out, shared_pin_oe,
    input wire logic [7:0] mem_addr, mem_wdata, mem_rdata, io_a_oe, io_a_out,
    input wire logic [1:0] mixed_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    wire wa = mem_wr && mem_addr == 8'h12;
    wire wc = mem_wr && mem_addr == 8'h16;
    sequence car_hi; shared_pin_out [*4]; endsequence
    a_od_low: assert property (io_a_out == 8'h00 && mixed_out == 2'h0) else $error("drain data high");
    a_push_pull: assert property (shared_pin_oe) else $error("pin not driven");
    a_upper_zero: assert property ($past(mem_addr) == 8'h16 |-> mem_rdata[7:1] == 7'h00) else $error("upper bits");
    a_oe_follow: assert property (wa |-> ##2 io_a_oe == ~$past(mem_wdata, 2)) else $error("oe wrong");
    a_oe_hold: assert property (!$past(wa, 2) |-> $stable(io_a_oe)) else $error("oe moved");
    a_stop_low: assert property (wc && mem_wdata[0] |-> ##2 !shared_pin_out) else $error("not stopped");
    a_car_wave: assert property ($rose(shared_pin_out) |-> car_hi ##1 !shared_pin_out) else $error("bad pulse");
    a_rst_clear: assert property (disable iff (1'b0) srst |=> io_a_oe == 8'h00 && !shared_pin_out) else $error("rst");
    a_wake_once: assert property (wake_ff |-> $past(halt_active) && !$past(wake_ff)) else $error("wake");
endmodule : pcu_port_unit_checker
bind pcu_port_unit pcu_port_unit_checker u_chk (.*);

// >>> pcu_port_unit_tb_top.sv
// bench: reads, pin levels, carrier duty, wake
// assumes pcu_pin_model as the board
`timescale 1ns/1ps
module pcu_port_unit_tb_top;
    logic clk_sys = 0, srst = 1, mem_wr = 0, halt_active = 0, rd_req = 0, rd_val = 0, wake_ff, shared_pin_out, shared_pin_oe;
    logic [7:0] mem_addr = 0, mem_wdata = 0, ext_a = 8'hff, ext_b = 8'hff, k = 0, wk = 0, q[$];
    logic [7:0] mem_rdata, io_a_in, io_a_out, io_a_oe, mixed_in;
    logic [1:0] mixed_out, mixed_oe;
    logic [31:0] s = 32'h0000_15e7;
    int errors = 0, tests_run = 0, i;
    initial forever #5 clk_sys = ~clk_sys;
    pcu_port_unit #(.WAKE_EN(8'h01)) DUT (.*);
    pcu_pin_model u_pins (.*);
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction : xs
    task automatic chk(input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end
    endtask : chk
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_sys) begin mem_addr <= a; mem_wdata <= d; mem_wr <= 1; end
        @(posedge clk_sys) mem_wr <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk_sys) begin mem_addr <= a; rd_req <= 1; q.push_back(e); end
        @(posedge clk_sys) rd_req <= 0;
    endtask : rd
    task automatic test_done;
        if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    always @(posedge clk_sys) begin
        rd_val <= rd_req;
        if (wake_ff === 1'b1) wk <= wk + 1;
        if (rd_val) chk(mem_rdata, q.pop_front());
    end
    initial begin #50000 errors++; test_done; end
    initial begin
        repeat (5) @(posedge clk_sys);
        srst <= 0;
        rd(8'h12, 8'hff); rd(8'h14, 8'hff); rd(8'h16, 8'h01); rd(8'h13, 8'h00);
        for (i = 0; i < 8; i++) begin
            s = xs(s);
            wr(8'h12, s[7:0]); wr(8'h14, s[15:8]); wr(8'h16, s[23:16] | 8'h01);
            ext_a <= s[31:24]; ext_b <= s[31:24];
            repeat (6) @(posedge clk_sys);
            rd(8'h12, s[7:0] & s[31:24]);
            rd(8'h14, {s[31:26], s[25:24] & s[9:8]}); rd(8'h16, 8'h01);
        end
        ext_b <= 8'hff; wr(8'h14, 8'hff); wr(8'h16, 8'h00);
        repeat (8) @(posedge clk_sys);
        for (i = 0; i < 32; i++) @(posedge clk_sys) k += shared_pin_out;
        chk(k, 8'h10);
        @(negedge shared_pin_out); wr(8'h16, 8'h01); repeat (4) @(posedge clk_sys);
        chk({7'h00, shared_pin_out}, 8'h00);
        halt_active <= 1; ext_b <= 8'hfd; repeat (10) @(posedge clk_sys);
        chk(wk, 8'h00);
        ext_b <= 8'hfc; repeat (10) @(posedge clk_sys);
        chk(wk, 8'h01);
        test_done;
    end
endmodule : pcu_port_unit_tb_top
